/* dwp_defines.vh */
// dual wiper two-wire write slave: constants
// assumes inclusion by the slave modules only
`ifndef DWP_DEFINES_VH
`define DWP_DEFINES_VH
`define DWP_ADDR_FIXED   4'h5
`define DWP_WIPER_RESET  8'h80
`define DWP_CMD_WIPER_A  8'h11
`define DWP_CMD_WIPER_B  8'h12
`define DWP_CMD_WIPER_AB 8'h13
`define DWP_BIT_LAST     3'h7
`endif

/* dwp_edge.v */
// edge and bus condition detector on synchronised scl/sda
// assumes inputs already pass through dwp_sync
`timescale 1ns/1ns
`default_nettype none
module dwp_edge (
    input  wire i_ref_clk,
    input  wire i_sys_rst,
    input  wire i_scl,
    input  wire i_sda,
    output wire o_scl_rise,
    output wire o_scl_fall,
    output wire o_start,
    output wire o_stop
);
    reg scl_d_r;
    reg sda_d_r;
    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= i_scl;
            sda_d_r <= i_sda;
        end
    end
    assign o_scl_rise = i_scl & ~scl_d_r;
    assign o_scl_fall = ~i_scl & scl_d_r;
    // data moving while clock stays high marks a frame edge
    assign o_start = i_scl & scl_d_r & sda_d_r & ~i_sda;
    assign o_stop  = i_scl & scl_d_r & ~sda_d_r & i_sda;
endmodule // dwp_edge
`default_nettype wire

/* dwp_master.sv */
// bus master model: drives the clock, pulls data low
// assumes a pull-up on data and the 100 MHz bench clock
`timescale 1ns/1ns
`default_nettype none
module dwp_master (
    input  wire logic clk,
    input  wire logic sda,
    output var  logic scl,
    output var  logic sda_low
);
    initial begin
        scl = 1'h1;
        sda_low = 1'h0;
    end
    // a quarter bit of 40 ns, moving just after an edge
    task automatic put(input logic c, input logic l);
        scl = c;
        sda_low = l;
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic start;
        put(scl, 1'h0);
        put(1'h1, 1'h0);
        put(1'h1, 1'h1);
        put(1'h0, 1'h1);
    endtask
    task automatic stop;
        put(1'h0, 1'h1);
        put(1'h1, 1'h1);
        put(1'h1, 1'h0);
    endtask
    // data changes only with the clock low, never at its fall
    task automatic bit_io(input logic b, output logic seen);
        put(1'h0, !b);
        put(1'h1, !b);
        seen = sda;
        put(1'h1, !b);
        put(1'h0, !b);
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'h1, s);
        ack = !s;
    endtask
endmodule // dwp_master
`default_nettype wire

/* dwp_slave.v */
// dual wiper two-wire write slave top
// assumes scl/sda pins and straps are asynchronous to i_ref_clk
`timescale 1ns/1ns
`default_nettype none
`include "dwp_defines.vh"
module dwp_slave #(
    parameter WIPER_W = 8
) (
    input  wire               i_ref_clk,
    input  wire               i_sys_rst,
    input  wire               i_scl,
    input  wire               i_sda,
    input  wire               i_addr_strap_bit0,
    input  wire               i_addr_strap_bit1,
    input  wire               i_addr_strap_bit2,
    output reg                o_sda_oe,
    output reg                o_sda_out,
    output reg  [WIPER_W-1:0] o_first_wiper_position,
    output reg  [WIPER_W-1:0] o_second_wiper_position
);
    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_ADDR = 6'h02;
    localparam [5:0] ST_CMD  = 6'h04;
    localparam [5:0] ST_DATA = 6'h08;
    localparam [5:0] ST_ACK  = 6'h10;
    localparam [5:0] ST_SKIP = 6'h20;

    wire       scl_s;
    wire       sda_s;
    wire [2:0] strap_s;
    wire       scl_rise;
    wire       scl_fall;
    wire       start_c;
    wire       stop_c;

    // scl is only ever sampled, never driven
    dwp_sync #(.RST_VAL(1'b1)) u_sync_scl (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   (i_scl),
        .o_sync    (scl_s)
    );
    dwp_sync #(.RST_VAL(1'b1)) u_sync_sda (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   (i_sda),
        .o_sync    (sda_s)
    );
    dwp_sync #(.RST_VAL(1'b0)) u_sync_a0 (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   (i_addr_strap_bit0),
        .o_sync    (strap_s[0])
    );
    dwp_sync #(.RST_VAL(1'b0)) u_sync_a1 (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   (i_addr_strap_bit1),
        .o_sync    (strap_s[1])
    );
    dwp_sync #(.RST_VAL(1'b0)) u_sync_a2 (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   (i_addr_strap_bit2),
        .o_sync    (strap_s[2])
    );
    dwp_edge u_edge (
        .i_ref_clk  (i_ref_clk),
        .i_sys_rst  (i_sys_rst),
        .i_scl      (scl_s),
        .i_sda      (sda_s),
        .o_scl_rise (scl_rise),
        .o_scl_fall (scl_fall),
        .o_start    (start_c),
        .o_stop     (stop_c)
    );

    reg [5:0]         state_r;
    reg [5:0]         ret_r;
    reg [7:0]         shift_r;
    reg [2:0]         bit_r;
    reg [7:0]         cmd_r;
    reg               ack_arm_r;
    reg               byte_done_r;

    wire [7:0] shift_in = {shift_r[6:0], sda_s};

    // address match on bits 7:1, the noop/write bit 0 is not compared
    function addr_hit;
        input [7:0] b;
        input [2:0] s;
        begin
            addr_hit = (b[7:4] == `DWP_ADDR_FIXED) && (b[3:1] == s);
        end
    endfunction

    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            state_r                 <= ST_IDLE;
            ret_r                   <= ST_IDLE;
            shift_r                 <= 8'h00;
            bit_r                   <= 3'h0;
            cmd_r                   <= 8'h00;
            ack_arm_r               <= 1'b0;
            byte_done_r             <= 1'b0;
            o_sda_oe                <= 1'b0;
            o_sda_out               <= 1'b0;
            o_first_wiper_position  <= `DWP_WIPER_RESET;
            o_second_wiper_position <= `DWP_WIPER_RESET;
        end else if (stop_c) begin
            state_r     <= ST_IDLE;
            o_sda_oe    <= 1'b0;
            ack_arm_r   <= 1'b0;
            byte_done_r <= 1'b0;
        end else if (start_c) begin
            // repeated start also restarts address phase
            state_r     <= ST_ADDR;
            bit_r       <= 3'h0;
            o_sda_oe    <= 1'b0;
            ack_arm_r   <= 1'b0;
            byte_done_r <= 1'b0;
        end else begin
            case (state_r)
            ST_IDLE: begin
                o_sda_oe <= 1'b0;
            end
            ST_ADDR, ST_CMD, ST_DATA: begin
                // sample on rising scl, data stable while high
                if (scl_rise) begin
                    shift_r     <= shift_in;
                    bit_r       <= bit_r + 3'h1;
                    byte_done_r <= (bit_r == `DWP_BIT_LAST);
                end
                if (scl_fall && byte_done_r) begin
                    byte_done_r <= 1'b0;
                    case (state_r)
                    ST_ADDR: begin
                        if (addr_hit(shift_r, strap_s)) begin
                            // noop still acked, later bytes ignored
                            o_sda_oe <= 1'b1;
                            state_r  <= ST_ACK;
                            ret_r    <= shift_r[0] ? ST_SKIP : ST_CMD;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                    ST_CMD: begin
                        cmd_r    <= shift_r;
                        o_sda_oe <= 1'b1;
                        state_r  <= ST_ACK;
                        ret_r    <= ST_DATA;
                    end
                    default: begin
                        if (cmd_r == `DWP_CMD_WIPER_A ||
                            cmd_r == `DWP_CMD_WIPER_AB)
                            o_first_wiper_position <= shift_r;
                        if (cmd_r == `DWP_CMD_WIPER_B ||
                            cmd_r == `DWP_CMD_WIPER_AB)
                            o_second_wiper_position <= shift_r;
                        o_sda_oe <= 1'b1;
                        state_r  <= ST_ACK;
                        // extra bytes are neither acked nor stored
                        ret_r    <= ST_SKIP;
                    end
                    endcase
                end
            end
            ST_ACK: begin
                // hold low through the ninth clock's high phase
                if (scl_rise)
                    ack_arm_r <= 1'b1;
                if (scl_fall && ack_arm_r) begin
                    o_sda_oe  <= 1'b0;
                    ack_arm_r <= 1'b0;
                    bit_r     <= 3'h0;
                    state_r   <= ret_r;
                end
            end
            ST_SKIP: begin
                o_sda_oe <= 1'b0;
            end
            default: begin
                state_r  <= ST_IDLE;
                o_sda_oe <= 1'b0;
            end
            endcase
        end
    end
    // 8-bit code maps one to one onto the 256 taps
endmodule // dwp_slave
`default_nettype wire

/* dwp_slave_properties.sv */
// checker on the wiper slave ports
// assumes bind onto dwp_slave, one clock domain
`timescale 1ns/1ns
`default_nettype none
module dwp_chk (
    input wire logic       i_ref_clk,
    input wire logic       i_sys_rst,
    input wire logic       i_scl,
    input wire logic       o_sda_oe,
    input wire logic [7:0] o_first_wiper_position,
    input wire logic [7:0] o_second_wiper_position
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    a_reset_mid: assert property (disable iff (1'h0)
        i_sys_rst |=> {o_first_wiper_position,
        o_second_wiper_position} == 16'h8080) else $error("wiper reset");
    a_reset_quiet: assert property (disable iff (1'h0)
        i_sys_rst |=> !o_sda_oe) else $error("oe in reset");
    a_first_on_ack: assert property (
        !$stable(o_first_wiper_position) |-> $rose(o_sda_oe))
        else $error("wiper a timing");
    a_second_on_ack: assert property (
        !$stable(o_second_wiper_position) |-> $rose(o_sda_oe))
        else $error("wiper b timing");
    a_ack_launch: assert property ($rose(o_sda_oe) |-> !i_scl)
        else $error("ack launch");
    a_ack_hold: assert property ($rose(o_sda_oe) |-> o_sda_oe[*8])
        else $error("ack short");
    a_ack_end: assert property ($rose(o_sda_oe) |-> ##[8:40] !o_sda_oe)
        else $error("ack long");
    a_ack_release: assert property ($fell(o_sda_oe) |-> !i_scl)
        else $error("release in high");
endmodule // dwp_chk
bind dwp_slave dwp_chk u_chk (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_scl(i_scl), .o_sda_oe(o_sda_oe),
    .o_first_wiper_position(o_first_wiper_position),
    .o_second_wiper_position(o_second_wiper_position));
`default_nettype wire

/* dwp_slave_tb.sv */
// bench for the dual wiper write slave
// assumes dwp_master as bus master, data line pulled up
`timescale 1ns/1ns
`default_nettype none
module dwp_slave_tb;
    logic       clk, rst, scl, m_low, oe, dout;
    logic [2:0] strap;
    logic [7:0] wa, wb;
    int         n_errors, cmp_count;
    wire        sda = !(m_low || oe);
    dwp_slave dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_scl(scl),
        .i_sda(sda), .i_addr_strap_bit0(strap[0]),
        .i_addr_strap_bit1(strap[1]), .i_addr_strap_bit2(strap[2]),
        .o_sda_oe(oe), .o_sda_out(dout), .o_first_wiper_position(wa),
        .o_second_wiper_position(wb));
    dwp_master m (.clk(clk), .sda(sda), .scl(scl), .sda_low(m_low));
    initial begin
        clk = 1'h0;
        forever #5 clk = !clk;
    end
    task automatic final_report;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk_pos(input logic [7:0] ea, eb);
        cmp_count++;
        if ({wa, wb} !== {ea, eb}) begin
            n_errors++;
            $display("Error wipers exp %h %h got %h %h", ea, eb, wa, wb);
        end
    endtask
    task automatic chk_dout(input logic e);
        cmp_count++;
        if (dout !== e) begin
            n_errors++;
            $display("Error sda_out exp %b got %b", e, dout);
        end
    endtask
    task automatic chk_ack(input logic [2:0] e, k);
        cmp_count++;
        if (k !== e) begin
            n_errors++;
            $display("Error acks exp %b got %b", e, k);
        end
    endtask
    task automatic xfer(input logic [6:0] a, input logic nop,
                        input logic [7:0] c, d, output logic [2:0] k);
        m.start();
        m.wbyte({a, nop}, k[2]);
        m.wbyte(c, k[1]);
        m.wbyte(d, k[0]);
        m.stop();
    endtask
    task automatic s_routes;
        logic [2:0] k;
        xfer(7'h2D, 1'h0, 8'h11, 8'h00, k);
        chk_ack(3'h7, k);
        chk_pos(8'h00, 8'h80);
        xfer(7'h2D, 1'h0, 8'h12, 8'hFF, k);
        chk_pos(8'h00, 8'hFF);
        xfer(7'h2D, 1'h0, 8'h13, 8'h5A, k);
        chk_pos(8'h5A, 8'h5A);
    endtask
    task automatic s_refused;
        logic [2:0] k;
        xfer(7'h2D, 1'h1, 8'h11, 8'h01, k);
        chk_ack(3'h4, k);
        xfer(7'h2D, 1'h0, 8'h14, 8'h02, k);
        chk_ack(3'h7, k);
        xfer(7'h6D, 1'h0, 8'h11, 8'h03, k);
        chk_ack(3'h0, k);
        chk_pos(8'h5A, 8'h5A);
    endtask
    task automatic s_strap;
        logic [2:0] k;
        strap = 3'h0;
        xfer(7'h2D, 1'h0, 8'h11, 8'h04, k);
        chk_ack(3'h0, k);
        xfer(7'h28, 1'h0, 8'h12, 8'h7F, k);
        chk_pos(8'h5A, 8'h7F);
        chk_dout(1'h0);
    endtask
    initial begin
        rst = 1'h1;
        strap = 3'h5;
        n_errors = 0;
        cmp_count = 0;
        repeat (12) @(posedge clk);
        #1 rst = 1'h0;
        repeat (3) @(posedge clk);
        #1 chk_pos(8'h80, 8'h80);
        s_routes;
        s_refused;
        s_strap;
        final_report;
    end
    initial begin
        #500000;
        n_errors++;
        final_report;
    end
endmodule // dwp_slave_tb
`default_nettype wire

/* dwp_sync.v */
// two-flop synchroniser for asynchronous pin levels
// assumes the destination clock samples i_async
`timescale 1ns/1ns
`default_nettype none
module dwp_sync #(
    parameter RST_VAL = 1'b1
) (
    input  wire i_ref_clk,
    input  wire i_sys_rst,
    input  wire i_async,
    output wire o_sync
);
    reg meta_r;
    reg sync_r;
    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end
    assign o_sync = sync_r;
endmodule // dwp_sync
`default_nettype wire
